/* File: gtw_timer.sv */
// General 32-bit timer with capture and a 16-bit timer with watchdog mode.
// Assumes a register master on mclk_i and slow clocks arriving unsynchronised.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Two-flop synchroniser with rising-edge pulse taken past the second flop
module gtw_sync_rise (
   input  wire logic mclk_i,
   input  wire logic rst_i,
   input  wire logic async_i,
   output logic      rise_o
);
   logic meta;
   logic stable;
   logic stable_d;

   // Only the second flop reads the first one
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         meta     <= 1'b0;
         stable   <= 1'b0;
         stable_d <= 1'b0;
      end else begin
         meta     <= async_i;
         stable   <= meta;
         stable_d <= stable;
      end
   end

   assign rise_o = stable & ~stable_d;
endmodule

////////////////////////////////////////////////////////////////////////////
module gtw_timer
   import gtw_pkg::*;
#(
   parameter int N_IRQ = 32
) (
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   input  wire gtw_bus_t         bus_i,
   output logic [31:0]           rdata_o,
   input  wire logic             xtal_clk_i,
   input  wire logic             osc_clk_i,
   input  wire logic             gpio_clk_i,
   input  wire logic [N_IRQ-1:0] irq_src_i,
   output logic                  gt_irq_o,
   output logic                  wd_irq_o,
   output logic                  wd_reset_o,
   output logic                  adc_start_o
);

   logic [31:0] gt_load;
   logic [31:0] gt_val;
   logic [10:0] gt_ctl;
   logic [31:0] gt_cap;
   logic [8:0]  gt_csel;
   logic [14:0] gt_pre;
   logic [N_IRQ-1:0] irq_prev;
   logic [15:0] wd_load;
   logic [15:0] wd_val;
   logic [7:0]  wd_ctl;
   logic [7:0]  wd_pre;
   logic        wd_mode;
   logic [31:0] next_gt_val;
   logic [15:0] next_wd_val;

   ////////////////////////////////////////////////////////////////////////
   // Time-of-day step with carries between the packed fields
   function automatic logic [31:0] tod_step(input logic [31:0] v,
                                            input logic        up,
                                            input logic [7:0]  hmax);
      logic [7:0] h;
      logic [5:0] m;
      logic [5:0] s;
      logic [6:0] t;
      h = v[31:24];
      m = v[21:16];
      s = v[13:8];
      t = v[6:0];
      if (up) begin
         if (t != TOD_T_MAX) t = t + 7'h01;
         else begin
            t = 7'h00;
            if (s != TOD_MS_MAX) s = s + 6'h01;
            else begin
               s = 6'h00;
               if (m != TOD_MS_MAX) m = m + 6'h01;
               else begin
                  m = 6'h00;
                  h = (h == hmax) ? 8'h00 : h + 8'h01;
               end
            end
         end
      end else begin
         if (t != 7'h00) t = t - 7'h01;
         else begin
            t = TOD_T_MAX;
            if (s != 6'h00) s = s - 6'h01;
            else begin
               s = TOD_MS_MAX;
               if (m != 6'h00) m = m - 6'h01;
               else begin
                  m = TOD_MS_MAX;
                  h = (h == 8'h00) ? hmax : h - 8'h01;
               end
            end
         end
      end
      // Reserved gaps always come out as zero from the step
      tod_step = {h, 2'b00, m, 2'b00, s, 1'b0, t};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register decode
   wire wr_gt_load = bus_i.wr && bus_i.addr == GT_LOAD_ADDR;
   wire wr_gt_ctl  = bus_i.wr && bus_i.addr == GT_CTRL_ADDR;
   wire wr_gt_clr  = bus_i.wr && bus_i.addr == GT_CLR_ADDR;
   wire wr_gt_csel = bus_i.wr && bus_i.addr == GT_CSEL_ADDR;
   // enabling write starts the count from the load value
   wire gt_start   = wr_gt_ctl && bus_i.wdata[GT_EN_BIT];
   wire wr_wd_load = bus_i.wr && bus_i.addr == WD_LOAD_ADDR && !wd_mode;
   wire wr_wd_ctl  = bus_i.wr && bus_i.addr == WD_CTRL_ADDR && !wd_mode;
   wire wr_wd_kick = bus_i.wr && bus_i.addr == WD_KICK_ADDR;
   wire wd_enter   = wr_wd_ctl && bus_i.wdata[WD_DOG_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Slow clock edges; core clock needs no crossing
   logic xtal_rise;
   logic osc_rise;
   logic gpio_rise;

   gtw_sync_rise u_sync_xtal (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .async_i (xtal_clk_i),
      .rise_o  (xtal_rise)
   );
   gtw_sync_rise u_sync_osc (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .async_i (osc_clk_i),
      .rise_o  (osc_rise)
   );
   gtw_sync_rise u_sync_gpio (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .async_i (gpio_clk_i),
      .rise_o  (gpio_rise)
   );

   ////////////////////////////////////////////////////////////////////////
   // General timer source and prescaler
   wire [1:0] gt_src  = gt_ctl[GT_SRC_HI:GT_SRC_LO];
   wire [3:0] gt_pcode = gt_ctl[GT_PRE_HI:0];
   wire       ext_rise = gt_csel[CSEL_GPIO_BIT] ? gpio_rise : xtal_rise;
   wire gt_src_tick = (gt_src == 2'b11) ? 1'b1 :
                      (gt_src == 2'b10) ? osc_rise : ext_rise;
   // divisor; unlisted codes divide by one
   wire [14:0] gt_div = (gt_pcode == PRE_16)    ? DIV_16 :
                        (gt_pcode == PRE_256)   ? DIV_256 :
                        (gt_pcode == PRE_32768) ? DIV_32768 : 15'h0000;
   wire gt_tick = gt_src_tick && gt_pre >= gt_div;
   wire gt_adv  = gt_tick && gt_ctl[GT_EN_BIT];

   ////////////////////////////////////////////////////////////////////////
   // General timer next value
   wire       gt_up  = gt_ctl[GT_UP_BIT];
   wire       gt_per = gt_ctl[GT_PER_BIT];
   wire [1:0] gt_fmt = gt_ctl[GT_FMT_HI:GT_FMT_LO];
   wire       gt_tod = gt_fmt == GTW_FMT_TOD23 || gt_fmt == GTW_FMT_TOD255;
   wire [7:0] gt_hmax = (gt_fmt == GTW_FMT_TOD23) ? TOD_H23 : TOD_H255;
   wire [31:0] gt_full = gt_tod ? {gt_hmax, 2'b00, TOD_MS_MAX, 2'b00,
                                   TOD_MS_MAX, 1'b0, TOD_T_MAX}
                                : 32'hffffffff;
   wire gt_at_end = gt_up ? (gt_val == gt_full) : (gt_val == 32'h00000000);
   wire [31:0] gt_step = gt_tod ? tod_step(gt_val, gt_up, gt_hmax) :
                         gt_up  ? gt_val + 32'h00000001
                                : gt_val - 32'h00000001;
   wire [31:0] gt_wrap = gt_per ? gt_load :
                         gt_up  ? 32'h00000000 : gt_full;
   assign next_gt_val = gt_start ? gt_load :
                        !gt_adv ? gt_val : gt_at_end ? gt_wrap : gt_step;
   wire gt_hit = gt_adv && !gt_start && (gt_up ? next_gt_val == gt_full
                                               : next_gt_val == 32'h00000000);

   // Capture on each rising edge of the selected source
   wire [4:0] cap_idx  = gt_csel[4:0];
   wire       cap_rise = gt_csel[CSEL_EN_BIT] && irq_src_i[cap_idx]
                         && !irq_prev[cap_idx];

   ////////////////////////////////////////////////////////////////////////
   // General timer registers
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         gt_load     <= '0;
         gt_val      <= GT_VALUE_RST;
         gt_ctl      <= '0;
         gt_csel     <= '0;
         gt_cap      <= '0;
         gt_pre      <= '0;
         irq_prev    <= '0;
         gt_irq_o    <= 1'b0;
         adc_start_o <= 1'b0;
      end else begin
         if (wr_gt_load) gt_load <= bus_i.wdata;
         if (wr_gt_ctl) gt_ctl <= bus_i.wdata[10:0];
         if (wr_gt_csel) gt_csel <= bus_i.wdata[8:0];
         // Restart prescale on reconfiguration
         if (wr_gt_ctl || gt_tick) gt_pre <= '0;
         else if (gt_src_tick) gt_pre <= gt_pre + 15'h0001;
         gt_val   <= next_gt_val;
         irq_prev <= irq_src_i;
         if (cap_rise) gt_cap <= gt_val;
         if (gt_hit) gt_irq_o <= 1'b1;
         else if (wr_gt_clr) gt_irq_o <= 1'b0;
         adc_start_o <= gt_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Watchdog-capable timer
   wire [1:0] wd_pcode = wd_ctl[WD_PRE_HI:WD_PRE_LO];
   // divide 1, 16 or 256; code 11 acts as 00
   wire [7:0] wd_div = (wd_pcode == 2'b01) ? DIV_16[7:0] :
                       (wd_pcode == 2'b10) ? DIV_256[7:0] : 8'h00;
   wire wd_tick = osc_rise && wd_pre >= wd_div;
   wire wd_adv  = wd_tick && (wd_ctl[WD_EN_BIT] || wd_mode);
   wire wd_reld = wd_ctl[WD_PER_BIT] || wd_mode;
   assign next_wd_val = wd_enter                 ? wd_load :
                        (wr_wd_kick && wd_mode)  ? wd_load :
                        !wd_adv                  ? wd_val :
                        (wd_val == 16'h0000)     ? (wd_reld ? wd_load
                                                            : 16'hffff)
                                                 : wd_val - 16'h0001;
   wire wd_hit = wd_adv && !wd_enter && !(wr_wd_kick && wd_mode)
                 && next_wd_val == 16'h0000;
   wire wd_to_irq = wd_hit && (!wd_mode || wd_ctl[WD_IRQ_BIT]);
   wire wd_to_rst = wd_hit && wd_mode && !wd_ctl[WD_IRQ_BIT];

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         wd_load    <= '0;
         wd_val     <= WD_VALUE_RST;
         wd_ctl     <= '0;
         wd_pre     <= '0;
         wd_mode    <= 1'b0;
         wd_irq_o   <= 1'b0;
         wd_reset_o <= 1'b0;
      end else begin
         if (wr_wd_load) wd_load <= bus_i.wdata[15:0];
         if (wr_wd_ctl) wd_ctl <= bus_i.wdata[7:0];
         if (wd_enter) wd_mode <= 1'b1;
         if (wr_wd_ctl || wd_tick) wd_pre <= '0;
         else if (osc_rise) wd_pre <= wd_pre + 8'h01;
         wd_val <= next_wd_val;
         if (wd_to_irq) wd_irq_o <= 1'b1;
         else if (wr_wd_kick) wd_irq_o <= 1'b0;
         wd_reset_o <= wd_to_rst;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data, valid only in the cycle after the read strobe
   // live value readback
   wire [31:0] next_rdata =
      !bus_i.rd                     ? 32'h00000000 :
      bus_i.addr == GT_LOAD_ADDR    ? gt_load :
      bus_i.addr == GT_VALUE_ADDR   ? gt_val :
      bus_i.addr == GT_CTRL_ADDR    ? {21'h000000, gt_ctl} :
      bus_i.addr == GT_CAP_ADDR     ? gt_cap :
      bus_i.addr == GT_CSEL_ADDR    ? {23'h000000, gt_csel} :
      bus_i.addr == WD_LOAD_ADDR    ? {16'h0000, wd_load} :
      bus_i.addr == WD_VALUE_ADDR   ? {16'h0000, wd_val} :
      bus_i.addr == WD_CTRL_ADDR    ? {24'h000000, wd_ctl} :
      bus_i.addr == STATUS_ADDR     ? {29'h00000000, wd_mode,
                                       wd_irq_o, gt_irq_o}
                                    : 32'h00000000;

   always_ff @(posedge mclk_i) begin
      if (rst_i) rdata_o <= '0;
      else rdata_o <= next_rdata;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_gt_expire;
      gt_hit;
   endsequence

   sequence s_kick;
      wr_wd_kick && wd_mode && !wd_enter;
   endsequence

   a_value_readback:
   assert property (@(posedge mclk_i) disable iff (rst_i)
      bus_i.rd && bus_i.addr == GT_VALUE_ADDR |=> rdata_o == $past(gt_val))
      else $error("value read returned wrong count");

   a_stopped_holds:
   assert property (@(posedge mclk_i) disable iff (rst_i)
      !gt_ctl[GT_EN_BIT] && !gt_start |=> gt_val == $past(gt_val))
      else $error("disabled timer changed");

   a_down_step:
   assert property (@(posedge mclk_i) disable iff (rst_i)
      gt_adv && !gt_start && !gt_up && !gt_tod && gt_val != 32'h00000000
      |=> gt_val == $past(gt_val) - 32'h00000001)
      else $error("down count step wrong");

   a_irq_on_expire:
   assert property (@(posedge mclk_i) disable iff (rst_i)
      s_gt_expire |=> gt_irq_o && adc_start_o)
      else $error("expiry missed interrupt or start");

   a_irq_clear:
   assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_gt_clr && !gt_hit |=> !gt_irq_o)
      else $error("interrupt not cleared");

   a_capture_latch:
   assert property (@(posedge mclk_i) disable iff (rst_i)
      cap_rise |=> gt_cap == $past(gt_val))
      else $error("capture missed count");

   a_wd_protect:
   assert property (@(posedge mclk_i) disable iff (rst_i)
      wd_mode |=> wd_load == $past(wd_load) && wd_ctl == $past(wd_ctl))
      else $error("protected register changed");

   a_wd_enter_load:
   assert property (@(posedge mclk_i) disable iff (rst_i)
      wd_enter |=> wd_mode && wd_val == $past(wd_load))
      else $error("watchdog entry did not load");

   a_wd_kick_reload:
   assert property (@(posedge mclk_i) disable iff (rst_i)
      s_kick |=> wd_val == $past(wd_load) && !wd_irq_o)
      else $error("kick did not reload");

   a_wd_expiry:
   assert property (@(posedge mclk_i) disable iff (rst_i)
      wd_hit && wd_mode |=> (wd_reset_o != $past(wd_ctl[WD_IRQ_BIT]))
                            ##1 !wd_reset_o)
      else $error("watchdog expiry action wrong");

endmodule

/* File: gtw_pkg.sv */
// Constants, register map and bus carrier of the general timer and watchdog.
// Assumes one 50 MHz core clock and a synchronous, active-high reset.
package gtw_pkg;

   // Register byte addresses
   localparam logic [31:0] GT_LOAD_ADDR  = 32'hffff0320;
   localparam logic [31:0] GT_VALUE_ADDR = 32'hffff0324;
   localparam logic [31:0] GT_CTRL_ADDR  = 32'hffff0328;
   localparam logic [31:0] GT_CLR_ADDR   = 32'hffff032c;
   localparam logic [31:0] GT_CAP_ADDR   = 32'hffff0330;
   localparam logic [31:0] GT_CSEL_ADDR  = 32'hffff0334;
   localparam logic [31:0] WD_LOAD_ADDR  = 32'hffff0360;
   localparam logic [31:0] WD_VALUE_ADDR = 32'hffff0364;
   localparam logic [31:0] WD_CTRL_ADDR  = 32'hffff0368;
   localparam logic [31:0] WD_KICK_ADDR  = 32'hffff036c;
   localparam logic [31:0] STATUS_ADDR   = 32'hffff0370;

   // Reset values
   localparam logic [31:0] GT_VALUE_RST = 32'h0fffffff;
   localparam logic [15:0] WD_VALUE_RST = 16'hffff;

   // General timer control and capture-select fields
   localparam int GT_SRC_HI  = 10;
   localparam int GT_SRC_LO  = 9;
   localparam int GT_UP_BIT  = 8;
   localparam int GT_EN_BIT  = 7;
   localparam int GT_PER_BIT = 6;
   localparam int GT_FMT_HI  = 5;
   localparam int GT_FMT_LO  = 4;
   localparam int GT_PRE_HI  = 3;
   localparam int CSEL_EN_BIT   = 7;
   localparam int CSEL_GPIO_BIT = 8;

   // Watchdog control fields
   localparam int WD_EN_BIT  = 7;
   localparam int WD_PER_BIT = 6;
   localparam int WD_DOG_BIT = 5;
   localparam int WD_PRE_HI  = 3;
   localparam int WD_PRE_LO  = 2;
   localparam int WD_IRQ_BIT = 1;

   // Prescale codes and divisors
   localparam logic [3:0] PRE_16    = 4'h4;
   localparam logic [3:0] PRE_256   = 4'h8;
   localparam logic [3:0] PRE_32768 = 4'hf;
   localparam logic [14:0] DIV_16    = 15'h000f;
   localparam logic [14:0] DIV_256   = 15'h00ff;
   localparam logic [14:0] DIV_32768 = 15'h7fff;

   // Time-of-day field limits
   localparam logic [7:0] TOD_H23 = 8'h17;
   localparam logic [7:0] TOD_H255 = 8'hff;
   localparam logic [5:0] TOD_MS_MAX = 6'h3b;
   localparam logic [6:0] TOD_T_MAX = 7'h7f;

   typedef enum logic [1:0] {
      GTW_FMT_BIN, GTW_FMT_RSVD, GTW_FMT_TOD23, GTW_FMT_TOD255
   } gtw_fmt_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } gtw_bus_t;

endpackage

/* File: gtw_timer_tb_top.sv */
// Self-checking bench for the general timer and watchdog block.
// Assumes the package is compiled first; the bench makes the slow clocks.
`timescale 1ns/1ps

module gtw_timer_tb_top;
   import gtw_pkg::*;

   logic        mclk_i;
   logic        rst_i;
   gtw_bus_t    bus_i;
   logic [31:0] rdata_o;
   logic [2:0]  slow;          // Pins: gpio, osc, xtal
   logic [31:0] irq_src_i;
   logic        gt_irq_o;
   logic        wd_irq_o;
   logic        wd_reset_o;
   logic        adc_start_o;
   int          mismatches   = 0;
   int          total_checks = 0;
   int          resets_seen  = 0;
   int          adc_seen     = 0;

   gtw_timer i_gtw_timer (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .bus_i       (bus_i),
      .rdata_o     (rdata_o),
      .xtal_clk_i  (slow[0]),
      .osc_clk_i   (slow[1]),
      .gpio_clk_i  (slow[2]),
      .irq_src_i   (irq_src_i),
      .gt_irq_o    (gt_irq_o),
      .wd_irq_o    (wd_irq_o),
      .wd_reset_o  (wd_reset_o),
      .adc_start_o (adc_start_o)
   );

   ////////////////////////////////////////////////////////////////////////
   // Clock, and counts of cycles with reset request or conversion start high
   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end

   always @(posedge mclk_i) begin
      if (wd_reset_o === 1'b1) begin
         resets_seen <= resets_seen + 1;
      end
      if (adc_start_o === 1'b1) begin
         adc_seen <= adc_seen + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Compare, bus and pin tasks
   task automatic chk_word(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_flag(input string what, input logic exp,
                           input logic got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk_i);
      bus_i <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
   endtask

   // Data are taken at the falling edge, well after they settle
   task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge mclk_i);
      bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge mclk_i);
      bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b0};
      @(negedge mclk_i);
      d = rdata_o;
   endtask

   task automatic rd_chk(input string what, input logic [31:0] a,
                         input logic [31:0] exp);
      logic [31:0] d;
      bus_rd(a, d);
      chk_word(what, exp, d);
   endtask

   // Slow pins idle low and need three core cycles to be seen
   task automatic tick(input int idx, input int n);
      repeat (n) begin
         repeat (4) @(posedge mclk_i);
         slow[idx] <= 1'b1;
         repeat (4) @(posedge mclk_i);
         slow[idx] <= 1'b0;
      end
      repeat (6) @(posedge mclk_i);
      @(negedge mclk_i);
   endtask

   task automatic do_reset;
      @(posedge mclk_i);
      rst_i <= 1'b1;
      repeat (10) @(posedge mclk_i);
      rst_i <= 1'b0;
   endtask

   task automatic give_verdict;
      if (mismatches == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset_values;
      logic [31:0] a [8] = '{GT_LOAD_ADDR, GT_VALUE_ADDR, GT_CTRL_ADDR,
         WD_LOAD_ADDR, WD_VALUE_ADDR, WD_CTRL_ADDR, STATUS_ADDR,
         32'hffff0380};
      logic [31:0] e [8] = '{32'h0, GT_VALUE_RST, 32'h0, 32'h0,
         {16'h0, WD_VALUE_RST}, 32'h0, 32'h0, 32'h0};
      for (int i = 0; i < 8; i++) begin
         rd_chk("reset value", a[i], e[i]);
      end
      chk_flag("gt irq idle", 1'b0, gt_irq_o);
   endtask

   task automatic t_reg_access;
      bus_wr(GT_LOAD_ADDR, 32'ha5a55a5a);
      rd_chk("gt load", GT_LOAD_ADDR, 32'ha5a55a5a);
      bus_wr(GT_VALUE_ADDR, 32'h1234);
      rd_chk("gt value ro", GT_VALUE_ADDR, GT_VALUE_RST);
      bus_wr(WD_LOAD_ADDR, 32'h12345678);
      rd_chk("wd load", WD_LOAD_ADDR, 32'h5678);
      bus_wr(WD_VALUE_ADDR, 32'h0);
      rd_chk("wd value ro", WD_VALUE_ADDR, 32'hffff);
      bus_wr(GT_CTRL_ADDR, 32'hfffff87f);
      rd_chk("gt ctrl", GT_CTRL_ADDR, 32'h7f);
      bus_wr(GT_CTRL_ADDR, 32'h77f);
      rd_chk("gt ctrl", GT_CTRL_ADDR, 32'h77f);
      rd_chk("stopped", GT_VALUE_ADDR, GT_VALUE_RST);
      bus_wr(GT_CTRL_ADDR, 32'h0);
      bus_wr(32'hffff0380, 32'hffffffff);
      rd_chk("unmapped", 32'hffff0380, 32'h0);
   endtask

   // Counts over a read-to-read gap of gap cycles on the core clock
   task automatic t_core(input logic [31:0] ctl, input int gap,
                         input logic [31:0] exp, input bit up);
      logic [31:0] v1;
      logic [31:0] v2;
      bus_wr(GT_CTRL_ADDR, ctl);
      bus_rd(GT_VALUE_ADDR, v1);
      repeat (gap - 2) @(posedge mclk_i);
      bus_rd(GT_VALUE_ADDR, v2);
      chk_word("core step", exp, up ? v2 - v1 : v1 - v2);
   endtask

   // Edges on every slow pin; only the selected one may count
   task automatic t_slow(input logic [31:0] ctl, input logic [31:0] csel,
                         input logic [31:0] exp);
      logic [31:0] v1;
      logic [31:0] v2;
      bus_wr(GT_CSEL_ADDR, csel);
      bus_wr(GT_CTRL_ADDR, ctl);
      bus_rd(GT_VALUE_ADDR, v1);
      tick(0, 3);
      tick(1, 5);
      tick(2, 2);
      bus_rd(GT_VALUE_ADDR, v2);
      chk_word("slow step", exp, v1 - v2);
   endtask

   task automatic t_capture;
      logic [31:0] v1;
      logic [31:0] v2;
      logic [31:0] c1;
      logic [31:0] c2;
      bus_wr(GT_CSEL_ADDR, 32'h83);
      bus_wr(GT_CTRL_ADDR, 32'h680);
      bus_rd(GT_VALUE_ADDR, v1);
      @(posedge mclk_i);
      irq_src_i[3] <= 1'b1;
      repeat (5) @(posedge mclk_i);
      bus_rd(GT_VALUE_ADDR, v2);
      bus_rd(GT_CAP_ADDR, c1);
      chk_flag("capture window", 1'b1, (c1 < v1) && (c1 > v2));
      @(posedge mclk_i);
      irq_src_i[5] <= 1'b1;
      repeat (5) @(posedge mclk_i);
      bus_rd(GT_CAP_ADDR, c2);
      chk_word("capture held", c1, c2);
      @(posedge mclk_i);
      irq_src_i <= 32'h0;
      @(posedge mclk_i);
      irq_src_i[3] <= 1'b1;
      bus_rd(GT_CAP_ADDR, c2);
      chk_flag("capture renewed", 1'b1, c2 < c1);
      bus_wr(GT_CTRL_ADDR, 32'h0);
      bus_wr(GT_CSEL_ADDR, 32'h0);
   endtask

   // Small load: one expiry then a free wrap, then periodic reloads
   task automatic t_gt_expire;
      int n0;
      bus_wr(GT_LOAD_ADDR, 32'h3);
      bus_wr(GT_CTRL_ADDR, 32'h680);
      @(negedge mclk_i);
      n0 = adc_seen;
      repeat (12) @(negedge mclk_i);
      chk_word("one start", n0 + 1, adc_seen);
      chk_flag("gt irq set", 1'b1, gt_irq_o);
      rd_chk("free wrap", GT_VALUE_ADDR, 32'hfffffff6);
      bus_wr(GT_CLR_ADDR, 32'h0);
      @(negedge mclk_i);
      chk_flag("gt irq clear", 1'b0, gt_irq_o);
      bus_wr(GT_CTRL_ADDR, 32'h6c0);
      @(negedge mclk_i);
      n0 = adc_seen;
      repeat (40) @(negedge mclk_i);
      chk_word("reload starts", n0 + 10, adc_seen);
      chk_flag("gt irq again", 1'b1, gt_irq_o);
      bus_wr(GT_CTRL_ADDR, 32'h0);
      bus_wr(GT_CLR_ADDR, 32'h0);
      @(negedge mclk_i);
      chk_flag("gt irq off", 1'b0, gt_irq_o);
   endtask

   task automatic t_wd_normal;
      bus_wr(WD_CTRL_ADDR, 32'h80);
      tick(1, 4);
      rd_chk("wd div1", WD_VALUE_ADDR, 32'hfffb);
      bus_wr(WD_CTRL_ADDR, 32'h84);
      tick(1, 32);
      rd_chk("wd div16", WD_VALUE_ADDR, 32'hfff9);
      bus_wr(WD_CTRL_ADDR, 32'h0);
   endtask

   // Watchdog left by the second reset only
   task automatic t_wd_irq;
      bus_wr(WD_LOAD_ADDR, 32'h5);
      bus_wr(WD_CTRL_ADDR, 32'h22);
      rd_chk("wd entry load", WD_VALUE_ADDR, 32'h5);
      tick(1, 3);
      rd_chk("wd down", WD_VALUE_ADDR, 32'h2);
      bus_wr(WD_KICK_ADDR, 32'h0);
      rd_chk("wd kick", WD_VALUE_ADDR, 32'h5);
      tick(1, 4);
      chk_flag("wd irq early", 1'b0, wd_irq_o);
      tick(1, 1);
      chk_flag("wd irq", 1'b1, wd_irq_o);
      rd_chk("status", STATUS_ADDR, 32'h6);
      bus_wr(WD_LOAD_ADDR, 32'h9);
      bus_wr(WD_CTRL_ADDR, 32'h0);
      rd_chk("wd load locked", WD_LOAD_ADDR, 32'h5);
      rd_chk("wd ctrl locked", WD_CTRL_ADDR, 32'h22);
      bus_wr(WD_KICK_ADDR, 32'hffffffff);
      repeat (2) @(negedge mclk_i);
      chk_flag("wd irq cleared", 1'b0, wd_irq_o);
      chk_word("no reset pulse", 32'h0, resets_seen);
      do_reset();
      rd_chk("wd ctrl after rst", WD_CTRL_ADDR, 32'h0);
   endtask

   task automatic t_wd_reset;
      bus_wr(WD_LOAD_ADDR, 32'h2);
      bus_wr(WD_CTRL_ADDR, 32'h20);
      tick(1, 1);
      chk_word("reset early", 32'h0, resets_seen);
      tick(1, 1);
      chk_word("reset pulse", 32'h1, resets_seen);
      chk_flag("no wd irq", 1'b0, wd_irq_o);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence and watchdog on the run itself
   initial begin
      rst_i     = 1'b1;
      bus_i     = '0;
      slow      = 3'h0;
      irq_src_i = 32'h0;
      do_reset();
      t_reset_values();
      t_reg_access();
      t_core(32'h680, 20, 32'd20, 1'b0);
      t_core(32'h780, 20, 32'd20, 1'b1);
      t_core(32'h690, 20, 32'd20, 1'b0);
      t_core(32'h600, 20, 32'd0, 1'b0);
      t_core(32'h684, 64, 32'd4, 1'b0);
      t_core(32'h688, 512, 32'd2, 1'b0);
      t_core(32'h68f, 512, 32'd0, 1'b0);
      t_slow(32'h080, 32'h0, 32'd3);
      t_slow(32'h280, 32'h0, 32'd3);
      t_slow(32'h480, 32'h0, 32'd5);
      t_slow(32'h080, 32'h100, 32'd2);
      t_capture();
      t_gt_expire();
      t_wd_normal();
      t_wd_irq();
      t_wd_reset();
      give_verdict();
   end

   initial begin
      repeat (20000) @(posedge mclk_i);
      mismatches++;
      give_verdict();
   end

endmodule
